// ---- lhd_pkg.sv ----
// Constants, field layouts and carrier types shared by the LPC host decode block.
package lhd_pkg;

	// ==========================================================
	// Register offsets inside the function 0 I/O window
	localparam logic [7:0] OFS_LEGACY_SEL = 8'h14;
	localparam logic [7:0] OFS_WIDE_BASE = 8'h18;
	localparam logic [7:0] OFS_ERR_CTRL = 8'h1c;
	localparam logic [7:0] OFS_ERR_LOC = 8'h20;

	// ==========================================================
	// Values after reset and writable masks
	localparam logic [31:0] RST_LEGACY_SEL = 32'h00080020;
	localparam logic [31:0] RST_WIDE_BASE = 32'h00000000;
	localparam logic [31:0] RST_ERR_CTRL = 32'h00000080;
	localparam logic [31:0] RST_ERR_LOC = 32'h00000000;
	localparam logic [31:0] MASK_LEGACY_SEL = 32'h007fffff;
	localparam logic [31:0] MASK_WIDE_BASE = 32'h0000fe00;
	localparam logic [31:0] MASK_ERR_CTRL = 32'h00000f00;

	// ==========================================================
	// Bit positions of the error and event control register
	localparam int unsigned BIT_PD_OVR_EN = 11;
	localparam int unsigned BIT_PD_OVR_VAL = 10;
	localparam int unsigned BIT_SIRQ_SMI_EN = 9;
	localparam int unsigned BIT_ERR_SMI_EN = 8;
	localparam int unsigned BIT_PD_STATUS = 7;
	localparam int unsigned BIT_SIRQ_STS = 6;
	localparam int unsigned BIT_ERR_STS = 5;
	localparam int unsigned BIT_MULTI_STS = 4;
	localparam int unsigned BIT_TIMEOUT_STS = 3;
	localparam int unsigned BIT_WRITE_STS = 2;
	localparam int unsigned BIT_DMA_STS = 1;
	localparam int unsigned BIT_MEM_STS = 0;

	// ==========================================================
	// Bit positions of the external decode enable register
	localparam int unsigned EN_PARALLEL = 0;
	localparam int unsigned EN_SERIAL0 = 1;
	localparam int unsigned EN_SERIAL1 = 2;
	localparam int unsigned EN_AUDIO = 3;
	localparam int unsigned EN_MIDI = 4;
	localparam int unsigned EN_SOUND = 5;
	localparam int unsigned EN_FLOPPY = 6;
	localparam int unsigned EN_GAME0 = 7;
	localparam int unsigned EN_GAME1 = 8;
	localparam int unsigned EN_WIDE = 9;
	localparam int unsigned NUM_RANGES = 10;

	// ==========================================================
	// Field positions of the select registers
	localparam int unsigned FLD_GAME1_LSB = 19;
	localparam int unsigned FLD_GAME0_LSB = 15;
	localparam int unsigned FLD_FLOPPY = 14;
	localparam int unsigned FLD_SOUND_LSB = 12;
	localparam int unsigned FLD_MIDI_LSB = 10;
	localparam int unsigned FLD_AUDIO_LSB = 8;
	localparam int unsigned FLD_SER1_LSB = 5;
	localparam int unsigned FLD_SER0_LSB = 2;
	localparam int unsigned FLD_PAR_LSB = 0;
	localparam int unsigned FLD_WIDE_LSB = 9;

	// ==========================================================
	// Port bases and range lengths
	localparam logic [15:0] GAME_BASE = 16'h0200;
	localparam logic [15:0] FLOPPY_PRI = 16'h03f0;
	localparam logic [15:0] FLOPPY_ALT = 16'h0370;
	localparam logic [15:0] MIDI_BASE = 16'h0300;
	localparam logic [15:0] AUDIO_BASE = 16'h0220;
	localparam logic [15:0] LEN_EIGHT = 16'h0008;
	localparam logic [15:0] LEN_MIDI = 16'h0002;
	localparam logic [15:0] LEN_AUDIO = 16'h0014;
	localparam logic [15:0] LEN_PAR_ALT = 16'h0004;
	localparam logic [15:0] SOUND_BASE [0:3] = '{16'h0530, 16'h0604, 16'h0e80, 16'h0f40};
	localparam logic [15:0] SERIAL_BASE [0:7] = '{16'h03f8, 16'h02f8, 16'h0220, 16'h0228,
		16'h0238, 16'h02e8, 16'h0338, 16'h03e8};
	localparam logic [15:0] PAR_BASE [0:2] = '{16'h0378, 16'h0278, 16'h03bc};
	localparam logic [1:0] PAR_CODE_ALT = 2'h2;
	localparam logic [1:0] PAR_CODE_RSVD = 2'h3;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] ofs;
		logic [31:0] data;
	} lhd_io_req_t;

	typedef struct packed {
		logic valid;
		logic timeout;
		logic write;
		logic dma;
		logic mem;
		logic [31:0] addr;
	} lhd_err_evt_t;

endpackage

// ---- lhd_port_decode.sv ----
// Legacy and wide window I/O address decoder for forwarding cycles to LPC.
module lhd_port_decode
	import lhd_pkg::*;
(
	// Cycle address
	input wire logic [15:0] addr,
	// Configuration
	input wire logic [31:0] portSel,
	input wire logic [31:0] windowBase,
	input wire logic [31:0] decodeEnable,
	// Result
	output logic hit
);

	// ==========================================================
	// Range check
	function automatic logic inRange(input logic [15:0] a, input logic [15:0] base,
		input logic [15:0] len);
		inRange = (a >= base) && (a < base + len);
	endfunction

	logic [NUM_RANGES-1:0] rangeHit;
	logic [1:0] sndCode;
	logic [1:0] midiCode;
	logic [1:0] audCode;
	logic [1:0] parCode;
	logic [15:0] parLen;

	// ==========================================================
	// Per range decode
	always_comb
	begin
		sndCode = portSel[FLD_SOUND_LSB +: 2];
		midiCode = portSel[FLD_MIDI_LSB +: 2];
		audCode = portSel[FLD_AUDIO_LSB +: 2];
		parCode = portSel[FLD_PAR_LSB +: 2];
		parLen = (parCode == PAR_CODE_ALT) ? LEN_PAR_ALT : LEN_EIGHT;
		rangeHit = '0;
		rangeHit[EN_GAME1] = addr == (GAME_BASE | {12'h0, portSel[FLD_GAME1_LSB +: 4]});
		rangeHit[EN_GAME0] = addr == (GAME_BASE | {12'h0, portSel[FLD_GAME0_LSB +: 4]});
		rangeHit[EN_FLOPPY] = inRange(addr, portSel[FLD_FLOPPY] ? FLOPPY_ALT : FLOPPY_PRI,
			LEN_EIGHT);
		rangeHit[EN_SOUND] = inRange(addr, SOUND_BASE[sndCode], LEN_EIGHT);
		rangeHit[EN_MIDI] = inRange(addr, MIDI_BASE + {10'h0, midiCode, 4'h0}, LEN_MIDI);
		rangeHit[EN_AUDIO] = inRange(addr, AUDIO_BASE + {9'h0, audCode, 5'h0}, LEN_AUDIO);
		rangeHit[EN_SERIAL1] = inRange(addr, SERIAL_BASE[portSel[FLD_SER1_LSB +: 3]],
			LEN_EIGHT);
		rangeHit[EN_SERIAL0] = inRange(addr, SERIAL_BASE[portSel[FLD_SER0_LSB +: 3]],
			LEN_EIGHT);
		// The reserved parallel code forwards nothing.
		rangeHit[EN_PARALLEL] = (parCode != PAR_CODE_RSVD) &&
			inRange(addr, PAR_BASE[parCode], parLen);
		rangeHit[EN_WIDE] = addr[15:FLD_WIDE_LSB] == windowBase[15:FLD_WIDE_LSB];
		hit = |(rangeHit & decodeEnable[NUM_RANGES-1:0]);
	end

endmodule // lhd_port_decode

// ---- lhd_lpc_cfg.sv ----
// LPC host configuration: port decode, power-down control and bus error status.
module lhd_lpc_cfg
	import lhd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register access through the I/O window
	input wire lhd_io_req_t ioReq,
	output logic [31:0] ioRdData,
	output logic ioRdValid,
	// Cycles to decode
	input wire logic [15:0] cycAddr,
	input wire logic cycValid,
	input wire logic [31:0] decodeEnable,
	output logic lpcForward,
	output logic forwardValid,
	// Bus events
	input wire lhd_err_evt_t errEvt,
	input wire logic serirqEvent,
	// Power-down
	input wire logic pmPowerDownN,
	output logic busPowerDownOutN,
	// SMI
	output logic topSmiStatus,
	output logic smiPulse
);

	// ==========================================================
	// Register state
	logic [31:0] legacySel;
	logic [31:0] wideBase;
	logic [11:0] errCtrl;
	logic [31:0] errLoc;
	logic [31:0] next_legacySel;
	logic [31:0] next_wideBase;
	logic [11:0] next_errCtrl;
	logic [31:0] next_errLoc;
	logic next_busPowerDownOutN;
	logic next_topSmiStatus;
	logic next_smiPulse;
	logic [31:0] next_ioRdData;
	logic next_ioRdValid;
	logic next_lpcForward;
	logic next_forwardValid;

	logic decodeHit;
	logic wrCtrl;
	logic [11:0] w1c;
	logic errSmi;
	logic sirqSmi;
	logic sirqCleared;
	logic errCleared;

	// ==========================================================
	// Address decode
	lhd_port_decode u_decode
	(
		.addr(cycAddr),
		.portSel(legacySel),
		.windowBase(wideBase),
		.decodeEnable(decodeEnable),
		.hit(decodeHit)
	);

	always_comb
	begin
		next_forwardValid = cycValid;
		next_lpcForward = cycValid && decodeHit;
	end

	// ==========================================================
	// Configuration writes
	// Only whole-word writes exist on this window; reserved bits are
	// masked off so they always read back as zero.
	always_comb
	begin
		next_legacySel = legacySel;
		next_wideBase = wideBase;
		if (ioReq.wr && ioReq.ofs == OFS_LEGACY_SEL)
		begin
			next_legacySel = ioReq.data & MASK_LEGACY_SEL;
		end
		if (ioReq.wr && ioReq.ofs == OFS_WIDE_BASE)
		begin
			next_wideBase = ioReq.data & MASK_WIDE_BASE;
		end
	end

	// ==========================================================
	// Error, event and power-down control
	always_comb
	begin
		wrCtrl = ioReq.wr && ioReq.ofs == OFS_ERR_CTRL;
		w1c = wrCtrl ? ioReq.data[11:0] : 12'h000;
		next_errCtrl = errCtrl;
		if (wrCtrl)
		begin
			next_errCtrl[11:8] = ioReq.data[11:8];
		end
		// Clears are applied first so a same-cycle event still sets the bit.
		next_errCtrl[BIT_SIRQ_STS] = errCtrl[BIT_SIRQ_STS] & ~w1c[BIT_SIRQ_STS];
		next_errCtrl[BIT_ERR_STS] = errCtrl[BIT_ERR_STS] & ~w1c[BIT_ERR_STS];
		next_errCtrl[BIT_MULTI_STS] = errCtrl[BIT_MULTI_STS] & ~w1c[BIT_MULTI_STS];
		next_errCtrl[3:0] = errCtrl[3:0] & ~w1c[3:0];
		if (serirqEvent)
		begin
			next_errCtrl[BIT_SIRQ_STS] = 1'b1;
		end
		if (errEvt.valid)
		begin
			next_errCtrl[BIT_ERR_STS] = 1'b1;
			if (errCtrl[BIT_ERR_STS])
			begin
				next_errCtrl[BIT_MULTI_STS] = 1'b1;
			end
			next_errCtrl[BIT_TIMEOUT_STS] = next_errCtrl[BIT_TIMEOUT_STS] | errEvt.timeout;
			next_errCtrl[BIT_WRITE_STS] = next_errCtrl[BIT_WRITE_STS] | errEvt.write;
			next_errCtrl[BIT_DMA_STS] = next_errCtrl[BIT_DMA_STS] | errEvt.dma;
			next_errCtrl[BIT_MEM_STS] = next_errCtrl[BIT_MEM_STS] | errEvt.mem;
		end
		// The pin status bit is not stored here; it is read from the output flop.
		next_errCtrl[BIT_PD_STATUS] = 1'b0;
		if (errCtrl[BIT_PD_OVR_EN])
		begin
			next_busPowerDownOutN = errCtrl[BIT_PD_OVR_VAL];
		end
		else
		begin
			next_busPowerDownOutN = pmPowerDownN;
		end
	end

	// ==========================================================
	// Shared top-level SMI status
	always_comb
	begin
		sirqSmi = serirqEvent && errCtrl[BIT_SIRQ_SMI_EN];
		errSmi = errEvt.valid && errCtrl[BIT_ERR_SMI_EN];
		sirqCleared = w1c[BIT_SIRQ_STS] && !errCtrl[BIT_ERR_STS];
		errCleared = w1c[BIT_ERR_STS] && !errCtrl[BIT_SIRQ_STS];
		next_topSmiStatus = topSmiStatus;
		if (sirqCleared || errCleared)
		begin
			next_topSmiStatus = 1'b0;
		end
		if (sirqSmi || errSmi)
		begin
			next_topSmiStatus = 1'b1;
		end
		next_smiPulse = sirqSmi || errSmi;
	end

	// ==========================================================
	// Error address capture
	always_comb
	begin
		next_errLoc = errLoc;
		if (errEvt.valid)
		begin
			next_errLoc = errEvt.addr;
		end
	end

	// ==========================================================
	// Read path
	// Reads take one cycle; unmapped offsets answer with zero.
	always_comb
	begin
		next_ioRdValid = ioReq.rd;
		next_ioRdData = 32'h00000000;
		if (ioReq.rd)
		begin
			case (ioReq.ofs)
				OFS_LEGACY_SEL:
				begin
					next_ioRdData = legacySel;
				end
				OFS_WIDE_BASE:
				begin
					next_ioRdData = wideBase;
				end
				OFS_ERR_CTRL:
				begin
					next_ioRdData = {20'h00000, errCtrl};
					next_ioRdData[BIT_PD_STATUS] = busPowerDownOutN;
				end
				OFS_ERR_LOC:
				begin
					next_ioRdData = errLoc;
				end
				default:
				begin
					next_ioRdData = 32'h00000000;
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			legacySel <= RST_LEGACY_SEL;
			wideBase <= RST_WIDE_BASE;
			errCtrl <= RST_ERR_CTRL[11:0] & ~(12'h001 << BIT_PD_STATUS);
			errLoc <= RST_ERR_LOC;
			busPowerDownOutN <= RST_ERR_CTRL[BIT_PD_STATUS];
			topSmiStatus <= 1'b0;
			smiPulse <= 1'b0;
			ioRdData <= 32'h00000000;
			ioRdValid <= 1'b0;
			lpcForward <= 1'b0;
			forwardValid <= 1'b0;
		end
		else
		begin
			legacySel <= next_legacySel;
			wideBase <= next_wideBase;
			errCtrl <= next_errCtrl;
			errLoc <= next_errLoc;
			busPowerDownOutN <= next_busPowerDownOutN;
			topSmiStatus <= next_topSmiStatus;
			smiPulse <= next_smiPulse;
			ioRdData <= next_ioRdData;
			ioRdValid <= next_ioRdValid;
			lpcForward <= next_lpcForward;
			forwardValid <= next_forwardValid;
		end
	end

endmodule // lhd_lpc_cfg

// ---- lhd_periph_model.sv ----
// Behavioural model of the LPC peripherals and power logic facing the host block.
module lhd_periph_model
	import lhd_pkg::*;
(
	// Clock
	input wire logic clk,
	// Events and levels towards the host
	output lhd_err_evt_t errEvt,
	output logic serirqEvent,
	output logic pmPowerDownN
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		errEvt = '0;
		serirqEvent = 1'b0;
		pmPowerDownN = 1'b1;
	end

	// ==========================================================
	// One event pulse: an LPC error with its class, or a serial IRQ.
	task automatic raise(input logic err, input logic [3:0] cls, input logic [31:0] a);
		errEvt = '{valid: err, timeout: cls[3], write: cls[2], dma: cls[1], mem: cls[0], addr: a};
		serirqEvent = ~err;
		@(posedge clk);
		#1;
		errEvt.valid = 1'b0;
		serirqEvent = 1'b0;
		// The address is not held after the pulse, so a stale capture shows up.
		errEvt.addr = ~a;
	endtask
endmodule // lhd_periph_model

// ---- lhd_lpc_cfg_properties.sv ----
// Concurrent checks on the ports of the LPC host configuration block.
module lhd_lpc_cfg_properties
	import lhd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register access
	input wire lhd_io_req_t ioReq,
	input wire logic [31:0] ioRdData,
	input wire logic ioRdValid,
	// Decode
	input wire logic cycValid,
	input wire logic [31:0] decodeEnable,
	input wire logic lpcForward,
	input wire logic forwardValid,
	// Events, power-down and SMI
	input wire lhd_err_evt_t errEvt,
	input wire logic serirqEvent,
	input wire logic busPowerDownOutN,
	input wire logic topSmiStatus,
	input wire logic smiPulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// ==========================================================
	// Properties
	chk_reset_outputs:
	assert property (disable iff (1'b0) !rstn |=> busPowerDownOutN && !topSmiStatus && !smiPulse)
		else $error("outputs not at rest after reset");
	chk_read_answer:
	assert property (ioReq.rd |=> ioRdValid)
		else $error("read without answer");
	chk_pd_status:
	assert property (ioReq.rd && ioReq.ofs == OFS_ERR_CTRL
		|=> ioRdData[BIT_PD_STATUS] == $past(busPowerDownOutN))
		else $error("power-down status bit differs from output");
	chk_pulse_cause:
	assert property (smiPulse |-> $past(errEvt.valid) || $past(serirqEvent))
		else $error("smi pulse without event");
	chk_top_rise:
	assert property ($rose(topSmiStatus) |-> smiPulse)
		else $error("top status set without smi");
	chk_top_fall:
	assert property ($fell(topSmiStatus) |-> $past(ioReq.wr) && $past(ioReq.ofs) == OFS_ERR_CTRL)
		else $error("top status cleared without write");
	chk_fwd_follows:
	assert property (cycValid |=> forwardValid)
		else $error("decode answer missing");
	chk_fwd_gated:
	assert property (cycValid && decodeEnable[9:0] == 10'h0 |=> !lpcForward)
		else $error("forward with all ranges disabled");
endmodule // lhd_lpc_cfg_properties

bind lhd_lpc_cfg lhd_lpc_cfg_properties lhd_lpc_cfg_properties_inst (.clk(clk), .rstn(rstn),
	.ioReq(ioReq), .ioRdData(ioRdData), .ioRdValid(ioRdValid), .cycValid(cycValid),
	.decodeEnable(decodeEnable), .lpcForward(lpcForward), .forwardValid(forwardValid),
	.errEvt(errEvt), .serirqEvent(serirqEvent), .busPowerDownOutN(busPowerDownOutN),
	.topSmiStatus(topSmiStatus), .smiPulse(smiPulse));

// ---- testbench.sv ----
// Self-checking testbench for the LPC host configuration block.
module testbench;
	import lhd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals and instances
	logic clk = 1'b0;
	logic rstn = 1'b0;
	lhd_io_req_t ioReq = '0;
	logic [15:0] cycAddr = 16'h0;
	logic cycValid = 1'b0;
	logic [31:0] decodeEnable = 32'h0;
	logic [31:0] ioRdData;
	logic ioRdValid, lpcForward, forwardValid, busPowerDownOutN, topSmiStatus, smiPulse;
	lhd_err_evt_t errEvt;
	logic serirqEvent, pmPowerDownN;
	int miscompares = 0;
	int nChecks = 0;

	always #10 clk = ~clk;

	lhd_lpc_cfg lhd_lpc_cfg_inst (.clk(clk), .rstn(rstn), .ioReq(ioReq), .ioRdData(ioRdData),
		.ioRdValid(ioRdValid), .cycAddr(cycAddr), .cycValid(cycValid),
		.decodeEnable(decodeEnable), .lpcForward(lpcForward), .forwardValid(forwardValid),
		.errEvt(errEvt), .serirqEvent(serirqEvent), .pmPowerDownN(pmPowerDownN),
		.busPowerDownOutN(busPowerDownOutN), .topSmiStatus(topSmiStatus), .smiPulse(smiPulse));
	lhd_periph_model lhd_periph_model_inst (.clk(clk), .errEvt(errEvt),
		.serirqEvent(serirqEvent), .pmPowerDownN(pmPowerDownN));

	// ==========================================================
	// Access tasks
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		nChecks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// Each access ends with an idle cycle, so no strobe is driven twice at one time.
	task automatic wr(input logic [7:0] ofs, input logic [31:0] data);
		ioReq = '{wr: 1'b1, rd: 1'b0, ofs: ofs, data: data};
		tick();
		ioReq = '0;
		tick();
	endtask
	task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
		ioReq = '{wr: 1'b0, rd: 1'b1, ofs: ofs, data: 32'h0};
		tick();
		ioReq = '0;
		check("read valid", 32'h1, {31'h0, ioRdValid});
		check($sformatf("register %h", ofs), exp, ioRdData);
		tick();
	endtask
	task automatic dec(input logic [15:0] a, input logic exp);
		cycAddr = a;
		cycValid = 1'b1;
		tick();
		cycValid = 1'b0;
		check("forward valid", 32'h1, {31'h0, forwardValid});
		check($sformatf("forward %h", a), {31'h0, exp}, {31'h0, lpcForward});
		tick();
	endtask
	task automatic rng(input logic [7:0] ofs, input logic [31:0] val, input int en,
		input logic [15:0] base, input logic [15:0] len);
		wr(ofs, val);
		decodeEnable = 32'h1 << en;
		dec(base, 1'b1);
		dec(base + len - 16'h1, 1'b1);
		dec(base + len, 1'b0);
		dec(base - 16'h1, 1'b0);
		decodeEnable = 32'h0;
		dec(base, 1'b0);
	endtask
	task automatic ev(input logic err, input logic [3:0] cls, input logic [31:0] a, input logic p);
		lhd_periph_model_inst.raise(err, cls, a);
		check("smi pulse", {31'h0, p}, {31'h0, smiPulse});
		tick();
	endtask
	task automatic top(input logic exp);
		check("top status", {31'h0, exp}, {31'h0, topSmiStatus});
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial
	begin
		repeat (6) @(posedge clk);
		#1;
		rstn = 1'b1;
		tick();
		rd(OFS_LEGACY_SEL, 32'h00080020);
		rd(OFS_WIDE_BASE, 32'h0);
		rd(OFS_ERR_CTRL, 32'h00000080);
		rd(OFS_ERR_LOC, 32'h0);
		rd(8'h24, 32'h0);
		wr(OFS_LEGACY_SEL, 32'hffffffff);
		rd(OFS_LEGACY_SEL, 32'h007fffff);
		wr(OFS_WIDE_BASE, 32'hffffffff);
		rd(OFS_WIDE_BASE, 32'h0000fe00);
		wr(OFS_ERR_LOC, 32'hffffffff);
		rd(OFS_ERR_LOC, 32'h0);
		$display("registers test done");
		for (int i = 0; i < 16; i++)
		begin
			rng(OFS_LEGACY_SEL, i << 15, EN_GAME0, 16'h200 + 16'(i), 16'h1);
			rng(OFS_LEGACY_SEL, i << 19, EN_GAME1, 16'h200 + 16'(i), 16'h1);
			if (i < 8)
			begin
				rng(OFS_LEGACY_SEL, i << 2, EN_SERIAL0, SERIAL_BASE[i], 16'h8);
				rng(OFS_LEGACY_SEL, i << 5, EN_SERIAL1, SERIAL_BASE[i], 16'h8);
			end
			if (i < 4)
			begin
				rng(OFS_LEGACY_SEL, i << 12, EN_SOUND, SOUND_BASE[i], 16'h8);
				rng(OFS_LEGACY_SEL, i << 10, EN_MIDI, 16'h300 + 16'(i) * 16'h10, 16'h2);
				rng(OFS_LEGACY_SEL, i << 8, EN_AUDIO, 16'h220 + 16'(i) * 16'h20, 16'h14);
			end
			if (i < 3)
				rng(OFS_LEGACY_SEL, i, EN_PARALLEL, PAR_BASE[i], (i == 2) ? 16'h4 : 16'h8);
		end
		rng(OFS_LEGACY_SEL, 32'h0, EN_FLOPPY, 16'h03f0, 16'h8);
		rng(OFS_LEGACY_SEL, 32'h4000, EN_FLOPPY, 16'h0370, 16'h8);
		wr(OFS_LEGACY_SEL, 32'h3);
		decodeEnable = 32'h1;
		dec(16'h0378, 1'b0);
		dec(16'h03bc, 1'b0);
		// The window sits clear of every legacy range, with reserved bits zero.
		rng(OFS_WIDE_BASE, 32'ha400, EN_WIDE, 16'ha400, 16'h200);
		$display("decode test done");
		lhd_periph_model_inst.pmPowerDownN = 1'b0;
		tick();
		check("power-down", 32'h0, {31'h0, busPowerDownOutN});
		rd(OFS_ERR_CTRL, 32'h0);
		wr(OFS_ERR_CTRL, 32'hc00);
		check("power-down", 32'h1, {31'h0, busPowerDownOutN});
		rd(OFS_ERR_CTRL, 32'hc80);
		lhd_periph_model_inst.pmPowerDownN = 1'b1;
		wr(OFS_ERR_CTRL, 32'h800);
		check("power-down", 32'h0, {31'h0, busPowerDownOutN});
		wr(OFS_ERR_CTRL, 32'h0);
		check("power-down", 32'h1, {31'h0, busPowerDownOutN});
		$display("power-down test done");
		wr(OFS_ERR_CTRL, 32'h300);
		ev(1'b1, 4'b1000, 32'h12345678, 1'b1);
		top(1'b1);
		rd(OFS_ERR_CTRL, 32'h3a8);
		rd(OFS_ERR_LOC, 32'h12345678);
		ev(1'b1, 4'b0111, 32'h0000abcd, 1'b1);
		rd(OFS_ERR_CTRL, 32'h3bf);
		rd(OFS_ERR_LOC, 32'h0000abcd);
		ev(1'b0, 4'h0, 32'h0, 1'b1);
		rd(OFS_ERR_CTRL, 32'h3ff);
		wr(OFS_ERR_CTRL, 32'h320);
		top(1'b1);
		rd(OFS_ERR_CTRL, 32'h3df);
		wr(OFS_ERR_CTRL, 32'h35f);
		top(1'b0);
		rd(OFS_ERR_CTRL, 32'h380);
		wr(OFS_ERR_CTRL, 32'h0);
		ev(1'b0, 4'h0, 32'h0, 1'b0);
		ev(1'b1, 4'b0001, 32'h1, 1'b0);
		top(1'b0);
		rd(OFS_ERR_CTRL, 32'he1);
		$display("event test done");
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule // testbench
